// ===== rtl/gyro_data_register_block.v
// Summary of operation
// R1: Master uses only offsets 0x00, 0x07-0x0a
// R2: Rate word bit 0 is odd parity
// R3: Validity set only when all monitors good; code leaves monitor_flags[7] out of validity
// R4: Rate sample sits in bits 15:2
// R5: Soft reset bit resets whole device; code leaves the pin synchronisers running
// R6: Control bit 12 enables link parity
// R7: Bit 13 picks even or odd parity
// R8: Bad received parity clears status bit 9
// R9: Reading status clears parity error
// R10: Temperature word parity and validity bits
// R11: Temperature sample sits in bits 15:2
// R12: Master never writes factory fields
// R13: Parity mode makes words 17 clocks
// R14: Parity failure discards the write
// R15: Nonexistent address reads as zero
// R16: Master writes 0x04 to soft reset
`timescale 1ns/10ps
`include "gyro_regs_consts.vh"
module gyro_data_register_block (
  // System
  input wire clk_sys,
  input wire reset_n,
  // Serial link pins from the master
  input wire sck,
  input wire csn,
  input wire mosi,
  // Serial data pin back to the master
  output wire miso_o,
  output wire miso_oe_n,
  // Sensor side, same clock domain
  input wire [13:0] rate_sample,
  input wire [13:0] temp_sample,
  input wire [13:0] monitor_flags,
  // Control state seen by the system
  output wire link_parity_enable,
  output wire link_parity_polarity,
  output wire soft_reset_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Odd parity bit over bits 14:1, placed in bit 0
  function par_odd;
    input [15:0] w;
    begin
      par_odd = ~^w[14:1];
    end
  endfunction

  // Link parity bit: polarity 0 gives even ones, 1 gives odd ones
  function link_par;
    input [15:0] w;
    input pol;
    begin
      link_par = (^w) ^ pol; // see R7
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage feeds only the second

  reg [1:0] sck_s_q;
  reg [1:0] csn_s_q;
  reg [1:0] mosi_s_q;
  reg sck_d_q; // Delayed sck for edge finding
  reg csn_d_q; // Delayed csn for edge finding

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sck_s_q <= 2'h0;
      csn_s_q <= 2'h3;
      mosi_s_q <= 2'h0;
      sck_d_q <= 1'h0;
      csn_d_q <= 1'h1;
    end else begin
      sck_s_q <= {sck_s_q[0], sck};
      csn_s_q <= {csn_s_q[0], csn};
      mosi_s_q <= {mosi_s_q[0], mosi};
      sck_d_q <= sck_s_q[1];
      csn_d_q <= csn_s_q[1];
    end
  end

  wire sck_rise = sck_s_q[1] & ~sck_d_q;
  wire sck_fall = ~sck_s_q[1] & sck_d_q;
  wire csn_fall = ~csn_s_q[1] & csn_d_q;
  wire sel = ~csn_s_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // State

  reg par_en_q; // Parity checking on
  reg par_pol_q; // Parity polarity
  reg par_err_q; // Sticky parity error
  reg soft_q; // Soft reset request, one cycle
  reg [16:0] rx_q; // Receive shift register
  reg [16:0] tx_q; // Transmit shift register
  reg [16:0] next_q; // Word to send after current one
  reg load_q; // Next falling edge loads next_q
  reg [4:0] cnt_q; // Bits received in current word
  reg data_ph_q; // Expecting the data word of a write
  reg [6:0] wr_adr_q; // Target of pending write
  reg wr_bad_q; // Address word of pending write had bad parity

  ////////////////////////////////////////////////////////////////////////////
  // Register images

  wire [15:0] status_val;
  assign status_val = {monitor_flags[13:8], ~par_err_q, monitor_flags[6:0], 2'h0}; // see R8
  // Validity needs every monitor except monitor_flags[7], and parity health, good
  wire s_ok = &status_val[15:2]; // see R3

  wire [15:0] rate_raw = {rate_sample, s_ok, 1'h0}; // see R4
  wire [15:0] temp_raw = {temp_sample, s_ok, 1'h0}; // see R11
  wire [15:0] rate_val = {rate_raw[15:1], par_odd(rate_raw)}; // see R2
  wire [15:0] temp_val = {temp_raw[15:1], par_odd(temp_raw)}; // see R10
  wire [15:0] ident_val;
  assign ident_val = {2'h0, par_pol_q, par_en_q, 12'h000};

  // Status flag word sent at frame start and after write data
  wire [15:0] flags_raw = {14'h0000, s_ok, 1'h0};
  wire [15:0] flags_val = {flags_raw[15:1], par_odd(flags_raw)};

  ////////////////////////////////////////////////////////////////////////////
  // Word boundary decode

  // Word length follows parity mode at the moment of the check
  wire [4:0] word_len = par_en_q ? `LEN_PARITY : `LEN_PLAIN; // see R13
  wire [16:0] rx_next = {rx_q[15:0], mosi_s_q[1]};
  wire [15:0] rx_word = par_en_q ? rx_next[16:1] : rx_next[15:0];
  // Extra bit checked only in parity mode
  wire rx_bad = par_en_q & (link_par(rx_word, par_pol_q) != rx_next[0]); // see R7
  wire word_end = sel & sck_rise & (cnt_q == word_len - 5'h01);
  wire is_write = rx_word[`AW_RW];

  // Read decode; reserved and unknown addresses read zero
  reg [15:0] rd_val;
  always @* begin
    case (rx_word[`AW_ADR_HI:`AW_ADR_LO])
      `ADR_RATE: rd_val = rate_val;
      `ADR_IDENT: rd_val = ident_val;
      `ADR_STATUS: rd_val = status_val;
      `ADR_TEMP: rd_val = temp_val; // see R10 R11
      default: rd_val = 16'h0000; // see R15
    endcase
  end

  // Outgoing word with link parity bit appended
  function [16:0] frame_tx;
    input [15:0] w;
    input en;
    input pol;
    begin
      frame_tx = {w, en & link_par(w, pol)};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Main process; soft reset clears state synchronously

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      par_en_q <= 1'h0;
      par_pol_q <= 1'h0;
      par_err_q <= 1'h0;
      soft_q <= 1'h0;
      rx_q <= 17'h00000;
      tx_q <= 17'h00000;
      next_q <= 17'h00000;
      load_q <= 1'h0;
      cnt_q <= 5'h00;
      data_ph_q <= 1'h0;
      wr_adr_q <= 7'h00;
      wr_bad_q <= 1'h0;
    end else if (soft_q) begin
      // All main-process state back to reset values; pin synchronisers keep running
      par_en_q <= 1'h0; // see R5
      par_pol_q <= 1'h0;
      par_err_q <= 1'h0;
      soft_q <= 1'h0;
      rx_q <= 17'h00000;
      tx_q <= 17'h00000;
      next_q <= 17'h00000;
      load_q <= 1'h0;
      cnt_q <= 5'h00;
      data_ph_q <= 1'h0;
      wr_adr_q <= 7'h00;
      wr_bad_q <= 1'h0;
    end else if (!sel) begin
      // Deselected: frame aborted, next word is an address
      cnt_q <= 5'h00;
      data_ph_q <= 1'h0;
      load_q <= 1'h0;
      wr_bad_q <= 1'h0;
    end else if (csn_fall) begin
      // Frame start: status flags go out first
      tx_q <= frame_tx(flags_val, par_en_q, par_pol_q);
      cnt_q <= 5'h00;
      load_q <= 1'h0;
    end else begin
      if (sck_fall) begin
        // Shift out on falling edge, or start the queued word
        if (load_q) begin
          // Parity framed at load, so a mode written in the last word applies
          tx_q <= frame_tx(next_q[16:1], par_en_q, par_pol_q); // see R7 R13
          load_q <= 1'h0;
        end else begin
          tx_q <= {tx_q[15:0], 1'h0};
        end
      end
      if (sck_rise) begin
        // Sample on rising edge
        rx_q <= rx_next;
        cnt_q <= word_end ? 5'h00 : cnt_q + 5'h01;
      end
      if (word_end) begin
        load_q <= 1'h1;
        if (!data_ph_q) begin
          // Address word: answer with the addressed register
          next_q <= frame_tx(rd_val, par_en_q, par_pol_q);
          data_ph_q <= is_write;
          wr_adr_q <= rx_word[`AW_ADR_HI:`AW_ADR_LO];
          wr_bad_q <= rx_bad;
          if (rx_bad) begin
            par_err_q <= 1'h1; // see R8
          end else if (!is_write && rx_word[`AW_ADR_HI:`AW_ADR_LO] == `ADR_STATUS) begin
            par_err_q <= 1'h0; // see R9
          end
        end else begin
          // Data word: commit unless either word failed parity
          next_q <= frame_tx(flags_val, par_en_q, par_pol_q);
          data_ph_q <= 1'h0;
          if (rx_bad) begin
            par_err_q <= 1'h1; // see R14
          end
          if (!rx_bad && !wr_bad_q && wr_adr_q == `ADR_IDENT) begin
            // Only the control bits are writable; factory bits stay put
            par_en_q <= rx_word[`IC_PAR_EN]; // see R6
            par_pol_q <= rx_word[`IC_PAR_POL]; // see R7
            soft_q <= rx_word[`IC_SOFT_RST]; // see R5
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign miso_o = tx_q[16];
  assign miso_oe_n = ~sel;
  assign link_parity_enable = par_en_q;
  assign link_parity_polarity = par_pol_q;
  assign soft_reset_pulse = soft_q;

endmodule

// ===== rtl/gyro_regs_consts.vh
`ifndef GYRO_REGS_CONSTS_VH
`define GYRO_REGS_CONSTS_VH
// Register addresses
`define ADR_RATE 7'h00
`define ADR_IDENT 7'h07
`define ADR_STATUS 7'h08
`define ADR_RSVD 7'h09
`define ADR_TEMP 7'h0a
// Address word fields
`define AW_ADR_HI 9
`define AW_ADR_LO 3
`define AW_RW 2
// Control bits in the identification/control register
`define IC_SOFT_RST 2
`define IC_PAR_EN 12
`define IC_PAR_POL 13
// Status bit that reports link parity health
`define ST_PAR_OK 9
// Word lengths in serial clock cycles
`define LEN_PLAIN 5'h10
`define LEN_PARITY 5'h11
`endif

// ===== sim/gyro_regs_checker.sv
`timescale 1ns/10ps
// Port-level timing of the register block
module gyro_regs_checker (
  // System
  input wire clk_sys,
  input wire reset_n,
  // Link pins
  input wire sck,
  input wire csn,
  input wire miso_o,
  input wire miso_oe_n,
  // Control state
  input wire link_parity_enable,
  input wire link_parity_polarity,
  input wire soft_reset_pulse
);
  // One domain, so clock and disable are given once
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  a_oe_idle_off: assert property (csn [*3] |-> miso_oe_n) else $error("oe on idle");
  a_oe_sel_on: assert property (!csn [*3] |-> !miso_oe_n) else $error("oe off in frame");
  a_miso_hold_high: assert property ((sck && !csn && !soft_reset_pulse) [*4] |-> $stable(miso_o))
    else $error("miso moved while clock high");
  a_pulse_single: assert property (soft_reset_pulse |=> !soft_reset_pulse) else $error("long pulse");
  a_soft_clears_mode: assert property (soft_reset_pulse |=> !link_parity_enable && !link_parity_polarity)
    else $error("mode kept over soft reset");
  a_en_quiet_idle: assert property (csn [*5] |-> $stable(link_parity_enable)) else $error("enable moved");
  a_pol_quiet_idle: assert property (csn [*5] |-> $stable(link_parity_polarity)) else $error("pol moved");
  a_mode_off_start: assert property ($rose(reset_n) |-> !link_parity_enable && !soft_reset_pulse)
    else $error("mode set after reset");
  // Main scenarios reached
  c_soft: cover property (soft_reset_pulse);
  c_parity: cover property ($rose(link_parity_enable));
  c_frame: cover property ($fell(miso_oe_n));
endmodule
bind gyro_data_register_block gyro_regs_checker i_chk (.clk_sys(clk_sys), .reset_n(reset_n), .sck(sck),
  .csn(csn), .miso_o(miso_o), .miso_oe_n(miso_oe_n), .link_parity_enable(link_parity_enable),
  .link_parity_polarity(link_parity_polarity), .soft_reset_pulse(soft_reset_pulse));

// ===== sim/spi_master_model.sv
`timescale 1ns/10ps
// Far-side master; clock parked low outside frames
module spi_master_model (
  // Link toward the block
  output logic sck,
  output logic csn,
  output logic mosi,
  input wire miso_o
);
  initial begin
    sck = 1'b0;
    csn = 1'b1;
    mosi = 1'b0;
  end
  // Parity bits from the block that disagree with the chosen polarity
  int n_bad_par = 0;
  // Word MSB first, 800 ns per bit; parity bit last when pe, bad flips it
  task automatic xfer(input logic [15:0] w, input logic pe, input logic pol, input logic bad,
    output logic [15:0] r);
    for (int i = 15; i >= -1; i--) begin
      if (i >= 0 || pe) begin
        mosi = (i >= 0) ? w[i] : ^w ^ pol ^ bad;
        #400 sck = 1'b1;
        if (i >= 0) r[i] = miso_o;
        else if (miso_o !== (^r ^ pol)) n_bad_par++;
        #400 sck = 1'b0;
      end
    end
  endtask
  ////////////////////////////////////////
  // Address, data, then flags after a write; data line inverted on release
  task automatic frame(input logic [6:0] a, input logic wr, input logic [15:0] d, input logic pe,
    input logic pol, input logic bad, output logic [15:0] st, output logic [15:0] r);
    logic [15:0] x;
    logic take;
    csn = 1'b0;
    #400 xfer({6'h00, a, wr, 2'b00}, pe, pol, bad, st);
    xfer(d, pe, pol, bad, r);
    // An accepted control write sets the mode from the next word on
    take = wr && a == 7'h07 && !bad;
    if (take) begin
      pe = d[12];
      pol = d[13];
    end
    // Flags word follows a write unless a soft reset has ended the frame
    if (wr && !(take && d[2])) xfer(16'h0000, pe, pol, bad, x);
    #400 csn = 1'b1;
    mosi = ~mosi;
    #800;
  endtask
endmodule

// ===== sim/testbench.sv
`timescale 1ns/10ps
`include "gyro_regs_consts.vh"
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin n_errors++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end
module testbench;
  // Sources and bench state
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [13:0] rate = 14'h1a5b;
  logic [13:0] temp = 14'h2c31;
  logic [13:0] mon = 14'h3fff;
  logic pe = 1'b0;
  logic pp = 1'b0; // Link parity polarity the master uses
  logic pb = 1'b1;
  logic [15:0] st, r;
  wire sck, csn, mosi, miso_o, miso_oe_n, miso_line, pen, ppol, srp;
  // Released line reads inverted, so a late or early drive shows up
  assign miso_line = miso_oe_n ? ~miso_o : miso_o;
  int n_errors = 0;
  int samples_checked = 0;
  int n_pulse = 0;
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (srp === 1'b1) n_pulse++;
  gyro_data_register_block i_gyro_data_register_block (.clk_sys(clk_sys), .reset_n(reset_n), .sck(sck),
    .csn(csn), .mosi(mosi), .miso_o(miso_o), .miso_oe_n(miso_oe_n), .rate_sample(rate), .temp_sample(temp),
    .monitor_flags(mon), .link_parity_enable(pen), .link_parity_polarity(ppol), .soft_reset_pulse(srp));
  spi_master_model i_spi_master_model (.sck(sck), .csn(csn), .mosi(mosi), .miso_o(miso_line));
  ////////////////////////////////////////
  // Sample word with validity and odd parity over bits 14:1
  function automatic logic [15:0] word(input logic [13:0] v, input logic s);
    word = {v, s, 1'b0};
    word[0] = ~^word[14:1];
  endfunction
  // Status image; bit 9 is parity health
  function automatic logic [15:0] stat(input logic ok);
    stat = {mon[13:8], ok, mon[6:0], 2'b00};
  endfunction
  task automatic fr(input logic [6:0] a, input logic wr, input logic [15:0] d);
    i_spi_master_model.frame(a, wr, d, pe, pp, ~pb, st, r);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Hang guard, well over the run length
  initial begin
    #2000000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    fr(`ADR_RATE, 1'b0, 16'h0000);
    `CHK("flags", word(14'h0000, 1'b1), st)
    `CHK("rate", word(rate, 1'b1), r)
    @(negedge clk_sys) mon = 14'h3ffe;
    fr(`ADR_TEMP, 1'b0, 16'h0000);
    `CHK("temp", word(temp, 1'b0), r)
    fr(`ADR_STATUS, 1'b0, 16'h0000);
    `CHK("status", stat(1'b1), r)
    // Reads only, outside the control and status registers
    for (int a = 1; a < 10; a++) begin
      if (a != 7 && a != 8) begin
        fr(a[6:0], 1'b0, 16'h0000);
        `CHK("reserved", 16'h0000, r)
      end
    end
    fr(`ADR_IDENT, 1'b1, 16'h2000);
    `CHK("polarity", 1'b1, ppol)
    fr(`ADR_IDENT, 1'b1, 16'h3000);
    `CHK("ident", 16'h2000, r)
    `CHK("enable", 1'b1, pen)
    pe = 1'b1;
    pp = 1'b1;
    pb = 1'b0;
    fr(`ADR_IDENT, 1'b1, 16'h1000);
    `CHK("dropped write", 1'b1, ppol)
    pb = 1'b1;
    fr(`ADR_STATUS, 1'b0, 16'h0000);
    `CHK("parity error", stat(1'b0), r)
    fr(`ADR_STATUS, 1'b0, 16'h0000);
    `CHK("error cleared", stat(1'b1), r)
    @(negedge clk_sys) mon = 14'h3fff;
    fr(`ADR_RATE, 1'b0, 16'h0000);
    `CHK("parity rate", word(rate, 1'b1), r)
    fr(`ADR_IDENT, 1'b1, 16'h0004);
    `CHK("pulses", 1, n_pulse)
    `CHK("mode", 2'b00, {pen, ppol})
    // Plain framing again after soft reset, then even link parity
    pe = 1'b0;
    pp = 1'b0;
    fr(`ADR_RATE, 1'b0, 16'h0000);
    `CHK("rate after reset", word(rate, 1'b1), r)
    fr(`ADR_IDENT, 1'b1, 16'h1000);
    `CHK("even enable", 2'b10, {pen, ppol})
    pe = 1'b1;
    fr(`ADR_TEMP, 1'b0, 16'h0000);
    `CHK("even temp", word(temp, 1'b1), r)
    fr(7'h7f, 1'b0, 16'h0000);
    `CHK("unmapped", 16'h0000, r)
    `CHK("link parity", 0, i_spi_master_model.n_bad_par)
    report_and_stop();
  end
endmodule
